// ### pkg/flash_prog_cfg.svh
`ifndef FLASH_PROG_CFG_SVH
`define FLASH_PROG_CFG_SVH
// register addresses
`define ADDR_SECTOR_BASE_HIGH 8'hF6
`define ADDR_SECTOR_BASE_LOW 8'hF7
`define ADDR_USER_PROGRAM_UNLOCK 8'hF8
`define ADDR_FLASH_MODE_CONTROL 8'hF9
// field positions
`define MODE_MSB 7
`define MODE_LSB 4
`define ERASE_FAIL_BIT 3
`define START_BIT 0
`define SECTOR_LOW_BIT 7
// values
`define UNLOCK_CODE 8'hA5
`define RESET_BYTE 8'h00
// timing: least erase and lock times in ns, clock period in ns
`define CLK_PERIOD_NS 100
`define ERASE_TIME_NS 4000
`define LOCK_TIME_NS 1000
`endif

// ### pkg/flash_prog_pkg.sv
package flash_prog_pkg;
  typedef enum logic [3:0] {
    mode_program = 4'h5,
    mode_erase = 4'hA,
    mode_lock = 4'h6
  } flash_mode_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_erase = 2'b01,
    st_lock = 2'b10,
    st_done = 2'b11
  } seq_state_t;
endpackage

// ### hw/op_timer.sv
`timescale 1ns/1ps
// counts down a loaded cycle count and pulses done in the cycle after the last one
module op_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] remain_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remain_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        remain_q <= '0;
      end else if (load) begin
        busy <= 1'b1;
        remain_q <= count;
      end else if (busy) begin
        if (remain_q <= WIDTH'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain_q <= remain_q - WIDTH'(1);
      end
    end
  end
endmodule

// ### hw/flash_user_program_control.sv
`timescale 1ns/1ps
`include "flash_prog_cfg.svh"
module flash_user_program_control #(
  parameter int CNT_WIDTH = 16,
  parameter int ERASE_CYCLES = (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int LOCK_CYCLES = (`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic irq_enabled_pending,
  input wire logic erase_verify_fail,
  input wire logic code_load_instruction,
  input wire logic code_load_write,
  output logic [7:0] reg_rdata,
  output logic user_mode_en,
  output logic [15:0] sector_addr,
  output logic erase_pulse,
  output logic lock_pulse,
  output logic program_en,
  output logic busy,
  output logic irq_service
);
  logic [7:0] unlock_q;
  logic [3:0] mode_q;
  logic start_q;
  logic fail_q;
  logic [7:0] sec_hi_q;
  logic sec_lo_q;
  flash_prog_pkg::seq_state_t state_q;
  logic timer_load;
  logic [CNT_WIDTH-1:0] timer_count;
  logic timer_abort;
  logic timer_busy;
  logic timer_done;
  logic unlocked;
  logic wr_ctl;
  logic go_erase;
  logic go_lock;

  ////////////////////////////////////////////////////////////////////
  // register writes
  assign unlocked = (unlock_q == `UNLOCK_CODE);
  assign wr_ctl = reg_wr && reg_addr == `ADDR_FLASH_MODE_CONTROL && unlocked;
  assign go_erase = wr_ctl && reg_wdata[`START_BIT] && state_q == flash_prog_pkg::st_idle
    && reg_wdata[`MODE_MSB:`MODE_LSB] == flash_prog_pkg::mode_erase;
  assign go_lock = wr_ctl && reg_wdata[`START_BIT] && state_q == flash_prog_pkg::st_idle
    && reg_wdata[`MODE_MSB:`MODE_LSB] == flash_prog_pkg::mode_lock;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_q <= `RESET_BYTE;
    end else if (reg_wr && reg_addr == `ADDR_USER_PROGRAM_UNLOCK) begin
      unlock_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_hi_q <= `RESET_BYTE;
      sec_lo_q <= 1'b0;
    end else if (reg_wr && reg_addr == `ADDR_SECTOR_BASE_HIGH) begin
      sec_hi_q <= reg_wdata;
    end else if (reg_wr && reg_addr == `ADDR_SECTOR_BASE_LOW) begin
      sec_lo_q <= reg_wdata[`SECTOR_LOW_BIT]; // low seven bits are dropped
    end
  end

  // mode stays put while busy so the running operation is not retargeted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 4'h0;
    end else if (wr_ctl && state_q == flash_prog_pkg::st_idle) begin
      mode_q <= reg_wdata[`MODE_MSB:`MODE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= flash_prog_pkg::st_idle;
    end else begin
      unique case (state_q)
        flash_prog_pkg::st_idle: begin
          if (go_erase) begin
            state_q <= flash_prog_pkg::st_erase;
          end else if (go_lock) begin
            state_q <= flash_prog_pkg::st_lock;
          end
        end
        flash_prog_pkg::st_erase: begin
          if (irq_enabled_pending || timer_done) begin
            state_q <= flash_prog_pkg::st_done;
          end
        end
        flash_prog_pkg::st_lock: begin
          if (timer_done) begin
            state_q <= flash_prog_pkg::st_done;
          end
        end
        flash_prog_pkg::st_done: begin
          state_q <= flash_prog_pkg::st_idle;
        end
      endcase
    end
  end

  // a start with a reserved or program mode never leaves idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
    end else if (go_erase || go_lock) begin
      start_q <= 1'b1;
    end else if (state_q == flash_prog_pkg::st_done) begin
      start_q <= 1'b0;
    end
  end

  // the enable-and-pending line ignores the cpu mask on purpose
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_q <= 1'b0;
    end else if (go_erase) begin
      fail_q <= 1'b0;
    end else if (state_q == flash_prog_pkg::st_erase) begin
      if (irq_enabled_pending) begin
        fail_q <= 1'b1;
      end else if (timer_done) begin
        fail_q <= erase_verify_fail;
      end
    end
  end

  assign timer_load = go_erase || go_lock;
  assign timer_count = go_erase ? CNT_WIDTH'(ERASE_CYCLES) : CNT_WIDTH'(LOCK_CYCLES);
  assign timer_abort = state_q == flash_prog_pkg::st_erase && irq_enabled_pending;

  op_timer #(
    .WIDTH(CNT_WIDTH)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(timer_load),
    .count(timer_count),
    .abort(timer_abort),
    .busy(timer_busy),
    .done(timer_done)
  );

  ////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `RESET_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_FLASH_MODE_CONTROL:
          reg_rdata <= {mode_q, fail_q, 2'b00, start_q};
        `ADDR_USER_PROGRAM_UNLOCK: reg_rdata <= unlock_q;
        `ADDR_SECTOR_BASE_HIGH: reg_rdata <= sec_hi_q;
        `ADDR_SECTOR_BASE_LOW: reg_rdata <= {sec_lo_q, 7'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      user_mode_en <= 1'b0;
      sector_addr <= 16'h0000;
      erase_pulse <= 1'b0;
      lock_pulse <= 1'b0;
      program_en <= 1'b0;
      busy <= 1'b0;
      irq_service <= 1'b0;
    end else begin
      user_mode_en <= unlocked;
      sector_addr <= {sec_hi_q, sec_lo_q, 7'h00};
      erase_pulse <= go_erase;
      lock_pulse <= go_lock;
      // byte program depends on mode, unlock, the idle state and both code-load inputs, never on start
      program_en <= unlocked && mode_q == flash_prog_pkg::mode_program
        && state_q == flash_prog_pkg::st_idle && code_load_instruction
        && code_load_write;
      // held through the done step too, so a start issued as soon as busy falls is never refused
      busy <= timer_busy || go_erase || go_lock || state_q == flash_prog_pkg::st_erase
        || state_q == flash_prog_pkg::st_lock;
      irq_service <= state_q == flash_prog_pkg::st_erase && irq_enabled_pending;
    end
  end
endmodule

// ### tb/flash_ctrl_assertions.sv
`timescale 1ns/1ps
`include "flash_prog_cfg.svh"
module flash_ctrl_checker #(
  parameter int ERASE_CYCLES = 40
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic irq_enabled_pending,
  input wire logic user_mode_en,
  input wire logic erase_pulse,
  input wire logic lock_pulse,
  input wire logic busy,
  input wire logic irq_service
);
  localparam int EMAX = ERASE_CYCLES + 4;
  logic wr_ok, ctl, go, erasing_q, unl_q;
  logic [3:0] md;
  assign wr_ok = reg_wr && !busy;
  assign ctl = wr_ok && reg_addr == `ADDR_FLASH_MODE_CONTROL;
  assign go = ctl && unl_q && reg_wdata[0];
  assign md = reg_wdata[7:4];
  // own unlock model: the registered enable output lags a back-to-back write by one edge
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) unl_q <= 1'b0;
    else if (reg_wr && reg_addr == `ADDR_USER_PROGRAM_UNLOCK) unl_q <= reg_wdata == `UNLOCK_CODE;
  // an interrupt during a lock must not be judged as an erase abort
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) erasing_q <= 1'b0;
    else erasing_q <= erase_pulse || (erasing_q && busy);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  erase_go_a: assert property (go && md == 4'hA |=> erase_pulse && busy)
    else $error("erase not launched");
  lock_go_a: assert property (go && md == 4'h6 |=> lock_pulse && busy && !erase_pulse)
    else $error("lock not launched");
  reserved_go_a: assert property (
    go && md != 4'hA && md != 4'h6 |=> !busy && !erase_pulse && !lock_pulse)
    else $error("reserved mode launched");
  locked_ctl_a: assert property (ctl && !unl_q |=> !busy)
    else $error("locked control acted");
  unlock_a: assert property (
    wr_ok && reg_addr == `ADDR_USER_PROGRAM_UNLOCK
    |-> ##2 user_mode_en == ($past(reg_wdata, 2) == `UNLOCK_CODE)) else $error("unlock wrong");
  erase_end_a: assert property (erase_pulse |-> ##[1:EMAX] !busy)
    else $error("erase never ends");
  abort_a: assert property (erasing_q && busy && irq_enabled_pending |-> ##[1:2] !busy)
    else $error("erase not aborted");
  irq_src_a: assert property (irq_service |-> $past(irq_enabled_pending) ##1 !busy)
    else $error("bad irq service");
endmodule
bind flash_user_program_control flash_ctrl_checker #(.ERASE_CYCLES(ERASE_CYCLES)) i_chk (
  .clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .irq_enabled_pending, .user_mode_en,
  .erase_pulse, .lock_pulse, .busy, .irq_service);

// ### tb/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  input wire logic busy,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // released data flips so a stale byte is never mistaken for a fresh one
    reg_wdata <= ~d;
  endtask
  task automatic wait_idle(output logic ok);
    ok = 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 200 && !ok; i++) begin
      @(negedge clk);
      ok = (busy === 1'b0);
    end
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, reset_n, reg_wr, reg_rd, rd_d, ok, irq_enabled_pending, erase_verify_fail;
  logic code_load_instruction, code_load_write, user_mode_en, erase_pulse, lock_pulse;
  logic program_en, busy, irq_service;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rnd;
  logic [15:0] sector_addr;
  logic [7:0] exp_q[$];
  logic [15:0] ops[5] = '{16'hA1A0, 16'hA1A8, 16'h5058, 16'h6168, 16'h3138};
  int failures, n_tests;
  flash_user_program_control #(.ERASE_CYCLES(6), .LOCK_CYCLES(3)) i_dut (
    .clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .irq_enabled_pending,
    .erase_verify_fail, .code_load_instruction, .code_load_write, .reg_rdata,
    .user_mode_en, .sector_addr, .erase_pulse, .lock_pulse, .program_en, .busy, .irq_service);
  cpu_model i_cpu (.clk, .busy, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_cpu.acc(1'b0, a, 8'h00);
  endtask
  task automatic complete_run();
    if (exp_q.size() != 0) begin
      failures++;
      $display("BAD %0t reads left unanswered", $time);
    end
    $display("failures %0d tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic idle();
    i_cpu.wait_idle(ok);
    if (!ok) begin
      cmp(16'h0000, 16'hFFFF);
      complete_run();
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // read data lands one edge after the strobe; the oldest note is due then
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d === 1'b1) cmp(reg_rdata, exp_q.pop_front());
  initial begin
    failures = 0;
    n_tests = 0;
    reset_n = 1'b0;
    irq_enabled_pending = 1'b0;
    erase_verify_fail = 1'b0;
    code_load_instruction = 1'b0;
    code_load_write = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'hF8, 8'h00);
    i_cpu.acc(1'b1, 8'hF9, 8'hA1);
    rd(8'hF9, 8'h00);
    i_cpu.acc(1'b1, 8'hF8, 8'hA5);
    rd(8'hF8, 8'hA5);
    rnd = lfsr(8'h59);
    i_cpu.acc(1'b1, 8'hF6, rnd);
    i_cpu.acc(1'b1, 8'hF7, 8'hFF);
    rd(8'hF7, 8'h80);
    cmp(sector_addr, {rnd, 8'h80});
    for (int i = 0; i < 5; i++) begin
      erase_verify_fail <= (i == 1);
      i_cpu.acc(1'b1, 8'hF9, ops[i][15:8]);
      idle();
      rd(8'hF9, ops[i][7:0]);
    end
    erase_verify_fail <= 1'b0;
    i_cpu.acc(1'b1, 8'hF9, 8'hA1);
    rd(8'hF9, 8'hA1);
    irq_enabled_pending <= 1'b1;
    @(posedge clk);
    irq_enabled_pending <= 1'b0;
    idle();
    rd(8'hF9, 8'hA8);
    i_cpu.acc(1'b1, 8'hF9, 8'h50);
    code_load_instruction <= 1'b1;
    code_load_write <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp(program_en, 16'h0001);
    i_cpu.acc(1'b1, 8'hF8, 8'h00);
    i_cpu.acc(1'b1, 8'hF9, 8'hA1);
    rd(8'hF9, 8'h58);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule
